// ---- rtl/uart_flags_pkg.sv ----
// Constants, register map and carrier types for the UART line condition flags.
package uart_flags_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] EVENT_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] FLAGS_OFFSET = 8'h14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] FLAGS_RESET = 9'h060;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Field positions of serial_condition_flags
  // ----------------------------------------------------------------
  localparam int FLAG_DATA_READY = 0;
  localparam int FLAG_OVERRUN = 1;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_STOP_BIT_FAULT = 3;
  localparam int FLAG_BREAK = 4;
  localparam int FLAG_HOLD_EMPTY = 5;
  localparam int FLAG_TX_EMPTY = 6;
  localparam int FLAG_RX_FIFO_ERR = 7;
  localparam int FLAG_ADDR = 8;
  localparam int FLAG_WIDTH = 9;

  // ----------------------------------------------------------------
  // Field positions of the configuration register
  // ----------------------------------------------------------------
  localparam int CFG_QUEUE_ENABLE = 0;
  localparam int CFG_NINE_BIT = 1;
  localparam int CFG_PROG_HOLD_EMPTY = 2;
  localparam int CFG_TX_THRESH_LO = 4;
  localparam int CFG_TX_THRESH_HI = 5;
  localparam int CFG_INFRARED = 6;
  localparam int CFG_WIDTH = 7;

  // ----------------------------------------------------------------
  // Event bits, shared by the event status and mask registers
  // ----------------------------------------------------------------
  localparam int EV_ADDR = 0;
  localparam int EV_LINE_ERR = 1;
  localparam int EV_RX_FIFO_ERR = 2;
  localparam int EV_HOLD_EMPTY = 3;
  localparam int EV_WIDTH = 4;

  // ----------------------------------------------------------------
  // Transmit FIFO geometry and threshold levels
  // ----------------------------------------------------------------
  localparam int TX_LEVEL_WIDTH = 5;
  localparam logic [4:0] TX_THRESH_EMPTY = 5'h00;
  localparam logic [4:0] TX_THRESH_TWO = 5'h02;
  localparam logic [4:0] TX_THRESH_QUARTER = 5'h04;
  localparam logic [4:0] TX_THRESH_HALF = 5'h08;

  // Tags carried with every received character.
  typedef struct packed {
    logic ninth;
    logic parityErr;
    logic stopBitFault;
    logic breakSeen;
  } rx_tag_t;

  // Transmit path state as seen by the flag logic.
  typedef struct packed {
    logic shiftEmpty;
    logic holdEmpty;
    logic fifoEmpty;
    logic fifoFull;
    logic [4:0] fifoLevel;
  } tx_state_t;

endpackage : uart_flags_pkg

// ---- rtl/uart_line_condition_flags.sv ----
// Line and buffer condition flags of a UART, with APB registers and interrupt.
`timescale 1ns/1ns
module uart_line_condition_flags (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver, non-FIFO path; rxOverrun counts in both modes
  input wire logic rxCharDone,
  input wire uart_flags_pkg::rx_tag_t rxCharTag,
  input wire logic rxOverrun,
  // Receive FIFO head and contents
  input wire logic rxHeadValid,
  input wire logic rxHeadNew,
  input wire uart_flags_pkg::rx_tag_t rxHeadTag,
  input wire logic rxErrEnter,
  input wire logic rxErrBehindHead,
  // Transmit path
  input wire uart_flags_pkg::tx_state_t txState,
  input wire logic txLoad,
  input wire logic txWrite,
  // Configuration and interrupt
  output logic queue_config_enable,
  output logic infrared_mode,
  output logic irq
);

  // Set to zero where the programmable holding-empty feature is not built.
  localparam logic PROG_HOLD_EMPTY_BUILT = 1'b1;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // The four line error fields share lineErr_r and every other field of the flag word
  // lives in its own register, except bit 5 in programmable mode, which shows txState.fifoFull, so that no variable is written by more than one process.
  logic addrFlag_r;
  logic [uart_flags_pkg::FLAG_BREAK:uart_flags_pkg::FLAG_OVERRUN] lineErr_r;
  logic rxFifoErr_r;
  logic txEmpty_r;
  logic dataReady_r;
  logic [uart_flags_pkg::FLAG_WIDTH-1:0] flags;
  logic [uart_flags_pkg::FLAG_WIDTH-1:0] snap_r;
  logic [uart_flags_pkg::CFG_WIDTH-1:0] config_r;
  logic [uart_flags_pkg::EV_WIDTH-1:0] event_r;
  logic [uart_flags_pkg::EV_WIDTH-1:0] evSnap_r;
  logic [uart_flags_pkg::EV_WIDTH-1:0] mask_r;
  logic [31:0] prdata_r;
  logic holdSrcPrev_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic mapped;
  logic readFlags;
  logic readEvent;
  logic writeCfg;
  logic writeMask;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == uart_flags_pkg::CONFIG_OFFSET) || (paddr == uart_flags_pkg::EVENT_OFFSET) ||
                  (paddr == uart_flags_pkg::MASK_OFFSET) || (paddr == uart_flags_pkg::FLAGS_OFFSET);
  assign readFlags = access && !pwrite && (paddr == uart_flags_pkg::FLAGS_OFFSET);
  assign readEvent = access && !pwrite && (paddr == uart_flags_pkg::EVENT_OFFSET);
  assign writeCfg = access && pwrite && (paddr == uart_flags_pkg::CONFIG_OFFSET);
  assign writeMask = access && pwrite && (paddr == uart_flags_pkg::MASK_OFFSET);

  // Every register answers at once, so the slave never stretches a transfer.
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic fifoEn;
  logic nineBit;
  logic progMode;
  logic [1:0] txThreshSel;

  assign fifoEn = config_r[uart_flags_pkg::CFG_QUEUE_ENABLE];
  assign nineBit = config_r[uart_flags_pkg::CFG_NINE_BIT];
  assign progMode = PROG_HOLD_EMPTY_BUILT && config_r[uart_flags_pkg::CFG_PROG_HOLD_EMPTY] && fifoEn;
  assign txThreshSel = config_r[uart_flags_pkg::CFG_TX_THRESH_HI:uart_flags_pkg::CFG_TX_THRESH_LO];
  assign queue_config_enable = fifoEn;
  assign infrared_mode = config_r[uart_flags_pkg::CFG_INFRARED];

  // ----------------------------------------------------------------
  // Receive character reveal
  // ----------------------------------------------------------------
  // In FIFO mode the tags of a character only count once it stands at the
  // head, so software sees flags in the order the characters are read.
  logic reveal;
  uart_flags_pkg::rx_tag_t tag;

  assign reveal = fifoEn ? rxHeadNew : rxCharDone;
  assign tag = fifoEn ? rxHeadTag : rxCharTag;

  logic setAddr;
  logic setBreak;
  logic setStop;
  logic setParity;
  logic setOverrun;

  assign setAddr = reveal && nineBit && tag.ninth;
  // The break flag belongs to plain UART mode only, so an infrared link
  // never raises it.
  assign setBreak = reveal && tag.breakSeen && !infrared_mode;
  assign setStop = reveal && tag.stopBitFault;
  assign setParity = reveal && tag.parityErr;
  assign setOverrun = rxOverrun;

  // ----------------------------------------------------------------
  // Clear masks
  // ----------------------------------------------------------------
  // Only bits that were set when the read data was captured are cleared,
  // so an event landing between setup and access phases is kept.
  logic [uart_flags_pkg::FLAG_WIDTH-1:0] rdClr;
  logic errClearOk;

  assign errClearOk = rxHeadValid && (rxHeadTag.parityErr || rxHeadTag.stopBitFault ||
                      rxHeadTag.breakSeen) && !rxErrBehindHead;
  assign rdClr = readFlags ? snap_r : '0;

  // ----------------------------------------------------------------
  // Sticky receive flags and data ready
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrFlag_r <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_ADDR];
    end else begin
      addrFlag_r <= setAddr || (addrFlag_r && !rdClr[uart_flags_pkg::FLAG_ADDR]);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lineErr_r[uart_flags_pkg::FLAG_BREAK] <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_BREAK];
      lineErr_r[uart_flags_pkg::FLAG_STOP_BIT_FAULT] <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_STOP_BIT_FAULT];
      lineErr_r[uart_flags_pkg::FLAG_PARITY] <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_PARITY];
      lineErr_r[uart_flags_pkg::FLAG_OVERRUN] <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_OVERRUN];
    end else begin
      lineErr_r[uart_flags_pkg::FLAG_BREAK] <= setBreak ||
        (lineErr_r[uart_flags_pkg::FLAG_BREAK] && !rdClr[uart_flags_pkg::FLAG_BREAK]);
      lineErr_r[uart_flags_pkg::FLAG_STOP_BIT_FAULT] <= setStop ||
        (lineErr_r[uart_flags_pkg::FLAG_STOP_BIT_FAULT] && !rdClr[uart_flags_pkg::FLAG_STOP_BIT_FAULT]);
      lineErr_r[uart_flags_pkg::FLAG_PARITY] <= setParity ||
        (lineErr_r[uart_flags_pkg::FLAG_PARITY] && !rdClr[uart_flags_pkg::FLAG_PARITY]);
      lineErr_r[uart_flags_pkg::FLAG_OVERRUN] <= setOverrun ||
        (lineErr_r[uart_flags_pkg::FLAG_OVERRUN] && !rdClr[uart_flags_pkg::FLAG_OVERRUN]);
    end
  end

  // A receive FIFO error stays reported until the last bad entry is at the
  // head; clearing earlier would hide errors still waiting in the queue.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxFifoErr_r <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_RX_FIFO_ERR];
    end else if (!fifoEn) begin
      rxFifoErr_r <= 1'b0;
    end else begin
      rxFifoErr_r <= rxErrEnter ||
        (rxFifoErr_r && !(rdClr[uart_flags_pkg::FLAG_RX_FIFO_ERR] && errClearOk));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataReady_r <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_DATA_READY];
    end else begin
      dataReady_r <= rxHeadValid;
    end
  end

  // ----------------------------------------------------------------
  // Transmit flags
  // ----------------------------------------------------------------
  logic txIdle;
  logic holdEmptyNxt;
  logic holdEmptyNormal_r;

  assign txIdle = txState.shiftEmpty && (fifoEn ? txState.fifoEmpty : txState.holdEmpty);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txEmpty_r <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_TX_EMPTY];
    end else begin
      txEmpty_r <= txIdle;
    end
  end

  // A fresh write wins over a move into the shift register in the same cycle.
  always_comb begin
    holdEmptyNxt = holdEmptyNormal_r;
    if (txWrite) begin
      holdEmptyNxt = 1'b0;
    end else if (txLoad && (fifoEn ? txState.fifoEmpty : 1'b1)) begin
      holdEmptyNxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdEmptyNormal_r <= uart_flags_pkg::FLAGS_RESET[uart_flags_pkg::FLAG_HOLD_EMPTY];
    end else begin
      holdEmptyNormal_r <= holdEmptyNxt;
    end
  end

  // ----------------------------------------------------------------
  // Flag word as software reads it
  // ----------------------------------------------------------------
  // In programmable mode bit 5 is a live view of the transmit FIFO, so it
  // keeps no sticky state and a status read leaves it alone.
  always_comb begin
    flags = '0;
    flags[uart_flags_pkg::FLAG_DATA_READY] = dataReady_r;
    flags[uart_flags_pkg::FLAG_OVERRUN] = lineErr_r[uart_flags_pkg::FLAG_OVERRUN];
    flags[uart_flags_pkg::FLAG_PARITY] = lineErr_r[uart_flags_pkg::FLAG_PARITY];
    flags[uart_flags_pkg::FLAG_STOP_BIT_FAULT] = lineErr_r[uart_flags_pkg::FLAG_STOP_BIT_FAULT];
    flags[uart_flags_pkg::FLAG_BREAK] = lineErr_r[uart_flags_pkg::FLAG_BREAK];
    flags[uart_flags_pkg::FLAG_HOLD_EMPTY] = progMode ? txState.fifoFull : holdEmptyNormal_r;
    flags[uart_flags_pkg::FLAG_TX_EMPTY] = txEmpty_r;
    flags[uart_flags_pkg::FLAG_RX_FIFO_ERR] = rxFifoErr_r;
    flags[uart_flags_pkg::FLAG_ADDR] = addrFlag_r;
  end

  // ----------------------------------------------------------------
  // Holding-empty interrupt source
  // ----------------------------------------------------------------
  logic [uart_flags_pkg::TX_LEVEL_WIDTH-1:0] txThresh;
  logic holdSrc;

  always_comb begin
    case (txThreshSel)
      2'h0: txThresh = uart_flags_pkg::TX_THRESH_EMPTY;
      2'h1: txThresh = uart_flags_pkg::TX_THRESH_TWO;
      2'h2: txThresh = uart_flags_pkg::TX_THRESH_QUARTER;
      2'h3: txThresh = uart_flags_pkg::TX_THRESH_HALF;
      default: txThresh = uart_flags_pkg::TX_THRESH_EMPTY;
    endcase
  end

  assign holdSrc = progMode ? (txState.fifoLevel <= txThresh) : holdEmptyNormal_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdSrcPrev_r <= 1'b1;
    end else begin
      holdSrcPrev_r <= holdSrc;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  logic [uart_flags_pkg::EV_WIDTH-1:0] evSet;

  assign evSet[uart_flags_pkg::EV_ADDR] = setAddr;
  assign evSet[uart_flags_pkg::EV_LINE_ERR] = setBreak || setStop || setParity || setOverrun;
  assign evSet[uart_flags_pkg::EV_RX_FIFO_ERR] = fifoEn && rxErrEnter;
  assign evSet[uart_flags_pkg::EV_HOLD_EMPTY] = holdSrc && !holdSrcPrev_r;

  // Set wins over the read clear so that no event is lost.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      event_r <= uart_flags_pkg::EVENT_RESET;
    end else begin
      event_r <= evSet | (event_r & ~(readEvent ? evSnap_r : '0));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r <= uart_flags_pkg::MASK_RESET;
    end else if (writeMask) begin
      // Bits above the event fields are dropped on a write.
      mask_r <= pwdata[uart_flags_pkg::EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config_r <= uart_flags_pkg::CONFIG_RESET;
    end else if (writeCfg) begin
      // Bits above the configuration fields are dropped on a write.
      config_r <= pwdata[uart_flags_pkg::CFG_WIDTH-1:0];
    end
  end

  // Mask bits only gate the output; status bits record events regardless.
  assign irq = |(event_r & mask_r);

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
      snap_r <= '0;
      evSnap_r <= '0;
    end else if (setup && !pwrite) begin
      snap_r <= flags;
      evSnap_r <= event_r;
      case (paddr)
        uart_flags_pkg::FLAGS_OFFSET: prdata_r <= {23'h000000, flags};
        uart_flags_pkg::CONFIG_OFFSET: prdata_r <= {25'h0000000, config_r};
        uart_flags_pkg::EVENT_OFFSET: prdata_r <= {28'h0000000, event_r};
        uart_flags_pkg::MASK_OFFSET: prdata_r <= {28'h0000000, mask_r};
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

endmodule : uart_line_condition_flags

// ---- test/uart_flags_assertions.sv ----
// Concurrent checks on the ports of the UART line condition flags.
`timescale 1ns/1ns
module uart_flags_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Far side and outputs
  input wire logic rxCharDone,
  input wire uart_flags_pkg::rx_tag_t rxCharTag,
  input wire logic rxHeadNew,
  input wire uart_flags_pkg::rx_tag_t rxHeadTag,
  input wire uart_flags_pkg::tx_state_t txState,
  input wire logic queue_config_enable,
  input wire logic irq
);
  logic [6:0] cfgShadow_r;
  logic access, rdSetup, mapped;
  assign access = psel && penable;
  assign rdSetup = psel && !penable && !pwrite && paddr == uart_flags_pkg::FLAGS_OFFSET;
  assign mapped = paddr inside {uart_flags_pkg::CONFIG_OFFSET, uart_flags_pkg::EVENT_OFFSET,
    uart_flags_pkg::MASK_OFFSET, uart_flags_pkg::FLAGS_OFFSET};
  // The nine-bit and programmable mode bits are not on the ports, so a shadow of the configuration register is kept.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      cfgShadow_r <= uart_flags_pkg::CONFIG_RESET;
    else if (access && pwrite && paddr == uart_flags_pkg::CONFIG_OFFSET)
      cfgShadow_r <= pwdata[6:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_err_unmapped: assert property (access && !mapped |-> pslverr)
    else $error("pslverr low on unmapped access");
  a_err_mapped: assert property (access && mapped |-> !pslverr)
    else $error("pslverr high on mapped access");
  a_upper_zero: assert property (rdSetup |=> prdata[31:9] == 23'h0)
    else $error("upper flag bits not zero");
  a_addr_nine: assert property (!queue_config_enable && cfgShadow_r[1] && rxCharDone && rxCharTag.ninth
    ##2 rdSetup |=> prdata[8]) else $error("address flag missing");
  a_addr_head: assert property (queue_config_enable && cfgShadow_r[1] && rxHeadNew && rxHeadTag.ninth
    ##2 rdSetup |=> prdata[8]) else $error("address flag missing at head");
  a_full_shown: assert property (rdSetup && queue_config_enable && cfgShadow_r[2]
    |=> prdata[5] == $past(txState.fifoFull)) else $error("bit 5 not fifo full");
  a_empty_fifo: assert property (rdSetup && queue_config_enable && $stable(queue_config_enable)
    && $stable(txState) |=> prdata[6] == ($past(txState.shiftEmpty) && $past(txState.fifoEmpty)))
    else $error("tx empty wrong with fifo");
  a_empty_hold: assert property (rdSetup && !queue_config_enable && $stable(queue_config_enable)
    && $stable(txState) |=> prdata[6] == ($past(txState.shiftEmpty) && $past(txState.holdEmpty)))
    else $error("tx empty wrong without fifo");
  a_irq_mask: assert property (access && pwrite && paddr == uart_flags_pkg::MASK_OFFSET
    && pwdata[3:0] == 4'h0 |=> !irq) else $error("irq high with all masked");
  c_prog_read: cover property (rdSetup && cfgShadow_r[2]);
  c_irq: cover property (irq);
  c_head_addr: cover property (rxHeadNew && rxHeadTag.ninth);
endmodule : uart_flags_assertions

bind uart_line_condition_flags uart_flags_assertions u_uart_flags_assertions (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .rxCharDone(rxCharDone), .rxCharTag(rxCharTag),
  .rxHeadNew(rxHeadNew), .rxHeadTag(rxHeadTag), .txState(txState),
  .queue_config_enable(queue_config_enable), .irq(irq)
);

// ---- test/uart_far_model.sv ----
// Far-side model of the receive and transmit paths feeding the flag logic.
`timescale 1ns/1ns
module uart_far_model (
  // Clock
  input wire logic sys_clk,
  // Receiver
  output logic rxCharDone,
  output uart_flags_pkg::rx_tag_t rxCharTag,
  output logic rxOverrun,
  // Receive FIFO
  output logic rxHeadValid,
  output logic rxHeadNew,
  output uart_flags_pkg::rx_tag_t rxHeadTag,
  output logic rxErrEnter,
  output logic rxErrBehindHead,
  // Transmitter
  output uart_flags_pkg::tx_state_t txState,
  output logic txLoad,
  output logic txWrite
);
  initial begin
    {rxCharDone, rxHeadNew, rxErrEnter, rxOverrun, txLoad, txWrite} = 6'h00;
    {rxHeadValid, rxErrBehindHead} = 2'h0;
    rxCharTag = 4'h0;
    rxHeadTag = 4'h0;
    txState = 9'h1C0;
  end
  // One-cycle strobes; the character tag is only valid with its strobe, so it is inverted afterwards, while the head tag is held.
  task automatic strobe(input logic [5:0] sel, input logic [3:0] tag);
    @(posedge sys_clk);
    {rxCharDone, rxHeadNew, rxErrEnter, rxOverrun, txLoad, txWrite} <= sel;
    rxCharTag <= tag;
    if (sel[4])
      rxHeadTag <= tag;
    @(posedge sys_clk);
    {rxCharDone, rxHeadNew, rxErrEnter, rxOverrun, txLoad, txWrite} <= 6'h00;
    rxCharTag <= ~tag;
  endtask : strobe
  // The extra edge lets the registered copies of these levels settle before a read.
  task automatic levels(input logic headValid, input logic behind, input logic [8:0] ts);
    @(posedge sys_clk);
    rxHeadValid <= headValid;
    rxErrBehindHead <= behind;
    txState <= ts;
    @(posedge sys_clk);
  endtask : levels
endmodule : uart_far_model

// ---- test/tb.sv ----
// Self-checking testbench for the UART line condition flags.
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] FLG = uart_flags_pkg::FLAGS_OFFSET;
  localparam logic [7:0] CFG = uart_flags_pkg::CONFIG_OFFSET;
  localparam logic [7:0] EVT = uart_flags_pkg::EVENT_OFFSET;
  localparam logic [7:0] MSK = uart_flags_pkg::MASK_OFFSET;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxCharDone, rxOverrun, rxHeadValid, rxHeadNew, rxErrEnter, rxErrBehindHead;
  logic txLoad, txWrite, queueEnable, infrared, irq;
  uart_flags_pkg::rx_tag_t rxCharTag, rxHeadTag;
  uart_flags_pkg::tx_state_t txState;
  int failures = 0;
  int compares = 0;

  always #10 sys_clk = ~sys_clk;

  uart_line_condition_flags u_uart_line_condition_flags (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxCharDone(rxCharDone), .rxCharTag(rxCharTag), .rxOverrun(rxOverrun),
    .rxHeadValid(rxHeadValid), .rxHeadNew(rxHeadNew), .rxHeadTag(rxHeadTag),
    .rxErrEnter(rxErrEnter), .rxErrBehindHead(rxErrBehindHead), .txState(txState),
    .txLoad(txLoad), .txWrite(txWrite), .queue_config_enable(queueEnable),
    .infrared_mode(infrared), .irq(irq)
  );
  uart_far_model u_uart_far_model (
    .sys_clk(sys_clk), .rxCharDone(rxCharDone), .rxCharTag(rxCharTag), .rxOverrun(rxOverrun),
    .rxHeadValid(rxHeadValid), .rxHeadNew(rxHeadNew), .rxHeadTag(rxHeadTag), .rxErrEnter(rxErrEnter),
    .rxErrBehindHead(rxErrBehindHead), .txState(txState), .txLoad(txLoad), .txWrite(txWrite)
  );

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rdChk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic chkIrq(input logic e);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : chkIrq

  task automatic test_reset();
    rdChk(FLG, 32'hFFFFFFFF, 32'h60);
    rdChk(CFG, 32'hFFFFFFFF, 32'h0);
    rdChk(MSK, 32'hFFFFFFFF, 32'h0);
    rdChk(8'h10, 32'hFFFFFFFF, 32'h0);
  endtask : test_reset
  task automatic test_nine();
    wr(CFG, 32'h2);
    u_uart_far_model.strobe(6'h24, 4'hB);
    rdChk(FLG, 32'h11A, 32'h11A);
    rdChk(FLG, 32'h11A, 32'h0);
    u_uart_far_model.strobe(6'h20, 4'h8);
    wr(FLG, 32'h0);
    rdChk(CFG, 32'hFFFFFFFF, 32'h2);
    rdChk(FLG, 32'h100, 32'h100);
    u_uart_far_model.strobe(6'h20, 4'h0);
    rdChk(FLG, 32'h100, 32'h0);
  endtask : test_nine
  task automatic test_fifo();
    wr(CFG, 32'h3);
    @(negedge sys_clk);
    chk({31'h0, queueEnable}, 32'h1);
    u_uart_far_model.strobe(6'h20, 4'h8);
    rdChk(FLG, 32'h100, 32'h0);
    u_uart_far_model.levels(1'b1, 1'b1, 9'h1C0);
    u_uart_far_model.strobe(6'h18, 4'hC);
    rdChk(FLG, 32'h181, 32'h181);
    rdChk(FLG, 32'h180, 32'h80);
    u_uart_far_model.levels(1'b1, 1'b0, 9'h1C0);
    rdChk(FLG, 32'h80, 32'h80);
    rdChk(FLG, 32'h80, 32'h0);
  endtask : test_fifo
  task automatic test_tx();
    wr(CFG, 32'h40);
    @(negedge sys_clk);
    chk({31'h0, infrared}, 32'h1);
    u_uart_far_model.strobe(6'h20, 4'h1);
    rdChk(FLG, 32'h10, 32'h0);
    wr(CFG, 32'h0);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h140);
    rdChk(FLG, 32'h40, 32'h0);
    wr(CFG, 32'h1);
    rdChk(FLG, 32'h40, 32'h40);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h100);
    rdChk(FLG, 32'h40, 32'h0);
  endtask : test_tx
  task automatic test_irq();
    wr(MSK, 32'h8);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h040);
    u_uart_far_model.strobe(6'h01, 4'h0);
    rdChk(FLG, 32'h20, 32'h0);
    rdChk(EVT, 32'hF, 32'h7);
    u_uart_far_model.strobe(6'h02, 4'h0);
    chkIrq(1'b1);
    rdChk(FLG, 32'h20, 32'h20);
    rdChk(EVT, 32'h8, 32'h8);
    chkIrq(1'b0);
    wr(CFG, 32'h15);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h030);
    rdChk(FLG, 32'h20, 32'h20);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h005);
    rdChk(FLG, 32'h20, 32'h0);
    rdChk(EVT, 32'hF, 32'h0);
    chkIrq(1'b0);
    u_uart_far_model.levels(1'b0, 1'b0, 9'h002);
    chkIrq(1'b1);
    wr(MSK, 32'h0);
    chkIrq(1'b0);
  endtask : test_irq

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_nine();
    test_fifo();
    test_tx();
    test_irq();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    test_done();
  end
endmodule : tb
